/* File: hw/ucf_filter.sv */
module ucf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic s_valid,
    input wire logic [WIDTH-1:0] s_data,
    output logic s_ready,
    output logic m_valid,
    output logic [WIDTH-1:0] m_data,
    input wire logic m_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
    logic [AW:0] count, next_count;
    logic next_s_ready;
    logic push, pop;

    assign push = s_valid & s_ready;
    assign pop = m_valid & m_ready;
    assign m_valid = (count != '0);
    assign m_data = mem[rptr];

    always_comb begin
        next_wptr = wptr;
        next_rptr = rptr;
        if (push) begin
            next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
        end
        if (pop) begin
            next_rptr = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
        end
        next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
        // Registered ready: full is known from the next occupancy
        next_s_ready = (next_count < (AW + 1)'(DEPTH));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            s_ready <= 1'b0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
            s_ready <= next_s_ready;
        end
    end

    // Storage needs no reset; only written words are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= s_data;
        end
    end
endmodule

module ucf_filter #(
    parameter int NUM_FILT = ucf_pkg::NUM_FILT,
    parameter int FIFO_DEPTH = ucf_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] up_addr,
    input wire logic up_wr,
    input wire logic up_rd,
    input wire logic [7:0] up_wdata,
    output logic [7:0] up_rdata,
    input wire logic in_valid,
    input wire logic in_soc,
    input wire logic [7:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic out_soc,
    output logic [7:0] out_data,
    input wire logic out_ready,
    output logic ext_valid,
    output logic ext_soc,
    output logic [7:0] ext_data
);
    logic [7:0] ctrl [NUM_FILT];
    logic [31:0] pat [NUM_FILT];
    logic [31:0] chk [NUM_FILT];
    logic [31:0] live [NUM_FILT];
    logic [31:0] snap [NUM_FILT];
    logic [NUM_FILT-1:0] qualify;

    logic accept;
    logic [5:0] idx, next_idx, pos;
    logic [7:0] hdr [3];
    logic [7:0] next_hdr [3];
    logic [31:0] hdr_word;
    logic decide;
    logic dec_valid, next_dec_valid, dec_copy, next_dec_copy, dec_drop, next_dec_drop;
    logic any_copy, any_drop;

    logic f_valid, f_ready;
    logic [8:0] f_data;
    logic pop, head_soc, copy_eff, drop_eff;
    logic cur_copy, next_cur_copy, cur_drop, next_cur_drop;
    logic next_out_valid, next_out_soc, next_ext_valid, next_ext_soc;
    logic [7:0] next_out_data, next_ext_data, next_up_rdata;

    // Cells are longer than the FIFO, so a decision is always consumed
    // before the next cell's header completes; no header stall is needed
    ucf_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .s_valid(in_valid),
        .s_data({in_soc, in_data}),
        .s_ready(in_ready),
        .m_valid(f_valid),
        .m_data(f_data),
        .m_ready(pop)
    );

    // Header capture and per-cell decision
    assign accept = in_valid & in_ready;
    assign pos = in_soc ? 6'h00 : idx;
    assign decide = accept & (pos == 6'(ucf_pkg::HDR_BYTES - 1));
    assign hdr_word = {hdr[0], hdr[1], hdr[2], in_data};

    always_comb begin
        next_idx = idx;
        next_hdr = hdr;
        if (accept) begin
            next_idx = (pos == 6'h3F) ? pos : pos + 6'h01;
            if (pos < 6'(ucf_pkg::HDR_BYTES - 1)) begin
                next_hdr[pos[1:0]] = in_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idx <= 6'h00;
            hdr <= '{default: 8'h00};
        end else begin
            idx <= next_idx;
            hdr <= next_hdr;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_FILT; g++) begin : g_filt
            logic sel, match, act, cnt_rd;
            logic [7:0] next_ctrl;
            logic [31:0] next_pat, next_chk, next_live, next_snap;

            assign sel = (up_addr[7:4] == ucf_pkg::FILT_PAGE_BASE + 4'(g));
            // Mask one compares a bit, mask zero ignores it
            assign match = ~|((hdr_word ^ pat[g]) & chk[g]);
            assign qualify[g] = ctrl[g][ucf_pkg::CTRL_ENABLE]
                & (match == ctrl[g][ucf_pkg::CTRL_SENSE]);
            assign act = decide & qualify[g]
                & (ctrl[g][ucf_pkg::CTRL_COPY] | ctrl[g][ucf_pkg::CTRL_DISCARD]);
            assign cnt_rd = up_rd & sel & (up_addr[3:0] == ucf_pkg::OFS_CNT3);

            always_comb begin
                next_ctrl = ctrl[g];
                next_pat = pat[g];
                next_chk = chk[g];
                next_live = live[g];
                next_snap = snap[g];
                if (up_wr && sel) begin
                    if (up_addr[3:0] == ucf_pkg::OFS_CTRL) begin
                        next_ctrl = up_wdata & ucf_pkg::CTRL_RW_MASK;
                    end
                    for (int b = 0; b < ucf_pkg::HDR_BYTES; b++) begin
                        if (up_addr[3:0] == ucf_pkg::OFS_PAT1 + 4'(b)) begin
                            next_pat[31 - 8 * b -: 8] = up_wdata;
                        end
                        if (up_addr[3:0] == ucf_pkg::OFS_CHK1 + 4'(b)) begin
                            next_chk[31 - 8 * b -: 8] = up_wdata;
                        end
                    end
                end
                // MSB read freezes all four bytes and restarts the count
                if (cnt_rd) begin
                    next_snap = live[g];
                    next_live = ucf_pkg::CNT_RESET;
                end
                // An event in the clearing cycle still counts
                if (act) begin
                    if (cnt_rd) begin
                        next_live = 32'h00000001;
                    end else if (live[g] < ucf_pkg::CNT_SAT) begin
                        next_live = live[g] + 32'h00000001;
                    end
                end
            end

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    ctrl[g] <= ucf_pkg::CTRL_RESET;
                    pat[g] <= ucf_pkg::PAT_RESET;
                    chk[g] <= ucf_pkg::CHK_RESET;
                    live[g] <= ucf_pkg::CNT_RESET;
                    snap[g] <= ucf_pkg::CNT_RESET;
                end else begin
                    ctrl[g] <= next_ctrl;
                    pat[g] <= next_pat;
                    chk[g] <= next_chk;
                    live[g] <= next_live;
                    snap[g] <= next_snap;
                end
            end
        end
    endgenerate

    always_comb begin
        any_copy = 1'b0;
        any_drop = 1'b0;
        for (int f = 0; f < NUM_FILT; f++) begin
            any_copy = any_copy | (qualify[f] & ctrl[f][ucf_pkg::CTRL_COPY]);
            any_drop = any_drop | (qualify[f] & ctrl[f][ucf_pkg::CTRL_DISCARD]);
        end
    end

    // Output side: a cell head waits until its decision exists
    assign head_soc = f_data[8];
    assign pop = f_valid & (!head_soc | dec_valid) & (!out_valid | out_ready);
    assign copy_eff = head_soc ? dec_copy : cur_copy;
    assign drop_eff = head_soc ? dec_drop : cur_drop;

    always_comb begin
        next_dec_valid = dec_valid;
        next_dec_copy = dec_copy;
        next_dec_drop = dec_drop;
        next_cur_copy = cur_copy;
        next_cur_drop = cur_drop;
        if (pop && head_soc) begin
            next_dec_valid = 1'b0;
            next_cur_copy = dec_copy;
            next_cur_drop = dec_drop;
        end
        if (decide) begin
            next_dec_valid = 1'b1;
            next_dec_copy = any_copy;
            next_dec_drop = any_drop;
        end
        next_out_valid = out_valid & ~out_ready;
        next_out_soc = out_soc;
        next_out_data = out_data;
        if (pop && !drop_eff) begin
            next_out_valid = 1'b1;
            next_out_soc = head_soc;
            next_out_data = f_data[7:0];
        end
        next_ext_valid = pop & copy_eff;
        next_ext_soc = head_soc;
        next_ext_data = f_data[7:0];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dec_valid <= 1'b0;
            dec_copy <= 1'b0;
            dec_drop <= 1'b0;
            cur_copy <= 1'b0;
            cur_drop <= 1'b0;
            out_valid <= 1'b0;
            out_soc <= 1'b0;
            out_data <= 8'h00;
            ext_valid <= 1'b0;
            ext_soc <= 1'b0;
            ext_data <= 8'h00;
        end else begin
            dec_valid <= next_dec_valid;
            dec_copy <= next_dec_copy;
            dec_drop <= next_dec_drop;
            cur_copy <= next_cur_copy;
            cur_drop <= next_cur_drop;
            out_valid <= next_out_valid;
            out_soc <= next_out_soc;
            out_data <= next_out_data;
            ext_valid <= next_ext_valid;
            ext_soc <= next_ext_soc;
            ext_data <= next_ext_data;
        end
    end

    // Read data; lower count bytes come from the snapshot, so reading
    // out of order returns a stale value
    always_comb begin
        next_up_rdata = 8'h00;
        if (up_rd) begin
            for (int f = 0; f < NUM_FILT; f++) begin
                if (up_addr[7:4] == ucf_pkg::FILT_PAGE_BASE + 4'(f)) begin
                    case (up_addr[3:0])
                        ucf_pkg::OFS_CTRL: next_up_rdata = ctrl[f];
                        4'h4, 4'h5, 4'h6, 4'h7:
                            next_up_rdata = pat[f][31 - 8 * (up_addr[1:0]) -: 8];
                        4'h8, 4'h9, 4'hA, 4'hB:
                            next_up_rdata = chk[f][31 - 8 * (up_addr[1:0]) -: 8];
                        ucf_pkg::OFS_CNT3: next_up_rdata = live[f][31:24];
                        4'hD, 4'hE, ucf_pkg::OFS_CNT0:
                            next_up_rdata = snap[f][31 - 8 * (up_addr[1:0]) -: 8];
                        default: next_up_rdata = 8'h00;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            up_rdata <= 8'h00;
        end else begin
            up_rdata <= next_up_rdata;
        end
    end
endmodule

/* File: hw/ucf_pkg.sv */
// How it works
// - Mask bit one compares, zero ignores
// - Four 8-bit check masks per filter
// - Each copy or discard adds one
// - Counter saturates at 0x0FFFFFFF until read
// - 32-bit count in four bytes, clear_on_read
// - Copied cells go to extraction port
// - Sense picks matching or non-matching cells
// - Copy enable steers qualifying cells to extraction
// - Discard enable drops qualifying cells downstream
// - Four 8-bit header patterns per filter
package ucf_pkg;
    localparam int NUM_FILT = 4;
    localparam int HDR_BYTES = 4;
    localparam int CELL_BYTES = 53;
    localparam int FIFO_DEPTH = 8;
    // Filter n occupies address 0x(4+n)3 .. 0x(4+n)F
    localparam logic [3:0] FILT_PAGE_BASE = 4'h4;
    localparam logic [3:0] OFS_CTRL = 4'h3;
    localparam logic [3:0] OFS_PAT1 = 4'h4;
    localparam logic [3:0] OFS_CHK1 = 4'h8;
    localparam logic [3:0] OFS_CNT3 = 4'hC;
    localparam logic [3:0] OFS_CNT0 = 4'hF;
    localparam int CTRL_SENSE = 0;
    localparam int CTRL_DISCARD = 1;
    localparam int CTRL_COPY = 2;
    localparam int CTRL_ENABLE = 3;
    localparam logic [7:0] CTRL_RW_MASK = 8'h0F;
    localparam logic [7:0] CTRL_RESET = 8'h08;
    localparam logic [31:0] PAT_RESET = 32'h00000000;
    localparam logic [31:0] CHK_RESET = 32'h00000000;
    localparam logic [31:0] CNT_RESET = 32'h00000000;
    localparam logic [31:0] CNT_SAT = 32'h0FFFFFFF;
endpackage

/* File: verif/ucf_filter_chk.sv */
module ucf_filter_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] up_addr,
    input wire logic up_rd,
    input wire logic [7:0] up_rdata,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_soc,
    input wire logic [7:0] out_data,
    input wire logic out_ready,
    input wire logic ext_valid,
    input wire logic ext_soc
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    property p_rd_idle;
        !up_rd |=> up_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped;
        up_rd && (up_addr[7:4] < 4'h4 || up_addr[7:4] > 4'h7 || up_addr[3:0] < 4'h3)
            |=> up_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctrl_hi;
        up_rd && up_addr[3:0] == ucf_pkg::OFS_CTRL |=> up_rdata[7:4] == 4'h0;
    endproperty
    a_ctrl_hi: assert property (p_ctrl_hi) else $error("control upper bits set");
    // Saturation at 0x0FFFFFFF keeps the top nibble clear forever
    property p_sat;
        up_rd && up_addr[3:0] == ucf_pkg::OFS_CNT3 |=> up_rdata[7:4] == 4'h0;
    endproperty
    a_sat: assert property (p_sat) else $error("count above saturation");
    property p_out_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_soc);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output byte dropped");
    property p_out_whole;
        out_valid && out_ready && out_soc |=> (!(out_valid && out_soc)) [*8];
    endproperty
    a_out_whole: assert property (p_out_whole) else $error("forwarded cell cut");
    property p_ext_whole;
        ext_valid && ext_soc |=> (!(ext_valid && ext_soc)) [*8];
    endproperty
    a_ext_whole: assert property (p_ext_whole) else $error("copied cell cut");
    property p_full_hold;
        !in_ready && out_valid && !out_ready |=> !in_ready;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("buffer drained while stalled");
    c_copy: cover property (ext_valid && ext_soc);
    c_full: cover property (!in_ready);
    c_msb: cover property (up_rd && up_addr[3:0] == ucf_pkg::OFS_CNT3);
endmodule

bind ucf_filter ucf_filter_chk u_chk (.clk(clk), .rstn(rstn), .up_addr(up_addr),
    .up_rd(up_rd), .up_rdata(up_rdata), .in_ready(in_ready), .out_valid(out_valid),
    .out_soc(out_soc), .out_data(out_data), .out_ready(out_ready),
    .ext_valid(ext_valid), .ext_soc(ext_soc));

/* File: verif/ucf_cell_src.sv */
module ucf_cell_src (
    input wire logic clk,
    input wire logic in_ready,
    output logic in_valid,
    output logic in_soc,
    output logic [7:0] in_data,
    output logic busy,
    output logic stuck
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        in_valid = 1'b0;
        in_soc = 1'b0;
        in_data = 8'h00;
        busy = 1'b0;
        stuck = 1'b0;
    end
    // Whole cells only, byte held until taken; call at a falling edge
    task automatic send_cell(input logic [31:0] hdr, input int len);
        int n;
        int w;
        busy = 1'b1;
        for (n = 0; n < len; n++) begin
            in_valid = 1'b1;
            in_soc = (n == 0);
            in_data = (n < 4) ? hdr[31 - 8 * n -: 8] : 8'(n);
            // Ready is looked at mid-cycle, settled for the edge that takes the byte
            w = 0;
            while (!in_ready && w < 100) begin
                @(negedge clk);
                w++;
            end
            if (w >= 100) begin
                stuck = 1'b1;
                n = len;
            end else begin
                @(negedge clk);
            end
        end
        in_valid = 1'b0;
        in_soc = 1'b0;
        // Stale byte inverted so it never looks valid
        in_data = ~in_data;
        busy = 1'b0;
    endtask
endmodule

/* File: verif/atm_rx_user_cell_filter_bench.sv */
module atm_rx_user_cell_filter_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, up_wr = 0, up_rd = 0, out_ready = 1;
    logic [7:0] up_addr = 8'h00, up_wdata = 8'h00, up_rdata, out_data, ext_data, in_data, d;
    logic in_valid, in_soc, in_ready, out_valid, out_soc, ext_valid, ext_soc, src_busy, act;
    logic src_stuck;
    logic [7:0] exp_b1 = 8'h12;
    logic [7:0] modes [8] = '{8'h0F, 8'h0D, 8'h0B, 8'h0A, 8'h0E, 8'h07, 8'h09, 8'h0C};
    logic [31:0] cnt, exp_cnt;
    int miscompares = 0, total_checks = 0, out_bytes = 0, out_cells = 0, ext_bytes = 0;
    int ext_cells = 0, i, k, m, w, ob, eb;
    always #5 clk = ~clk;
    ucf_filter u_dut (.clk(clk), .rstn(rstn), .up_addr(up_addr), .up_wr(up_wr),
        .up_rd(up_rd), .up_wdata(up_wdata), .up_rdata(up_rdata), .in_valid(in_valid),
        .in_soc(in_soc), .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
        .out_soc(out_soc), .out_data(out_data), .out_ready(out_ready),
        .ext_valid(ext_valid), .ext_soc(ext_soc), .ext_data(ext_data));
    ucf_cell_src u_src (.clk(clk), .in_ready(in_ready), .in_valid(in_valid),
        .in_soc(in_soc), .in_data(in_data), .busy(src_busy), .stuck(src_stuck));
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        up_addr = a;
        up_wdata = v;
        up_wr = 1'b1;
        @(negedge clk);
        up_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        up_addr = a;
        up_rd = 1'b1;
        @(negedge clk);
        v = up_rdata;
        up_rd = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd_count(input int f, output logic [31:0] c);
        for (int j = 0; j < 4; j++) begin
            rd({4'(4 + f), 4'(12 + j)}, c[31 - 8 * j -: 8]);
        end
    endtask
    // Quiet for eight cycles means the pipe has emptied
    task automatic drain();
        int q;
        q = 0;
        w = 0;
        while ((src_busy || q < 8) && w < 500) begin
            @(negedge clk);
            w++;
            q = (out_valid || ext_valid) ? 0 : q + 1;
        end
        if (w >= 500 || src_stuck) begin
            miscompares++;
            summarize();
        end
    endtask
    always @(posedge clk) begin
        if (out_valid && out_ready) begin
            out_bytes++;
            out_cells += out_soc;
            if (out_soc) begin
                check(out_data, exp_b1);
            end
        end
        if (ext_valid) begin
            ext_bytes++;
            if (ext_soc) begin
                ext_cells++;
                check(ext_data, exp_b1);
            end
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        for (i = 0; i < 4; i++) begin
            for (k = 3; k < 16; k++) begin
                rd({4'(4 + i), 4'(k)}, d);
                check(d, (k == 3) ? 8'h08 : 8'h00);
            end
        end
        wr(8'h43, 8'hFF);
        rd(8'h43, d);
        check(d, 8'h0F);
        wr(8'h43, 8'h08);
        wr(8'h20, 8'h55);
        rd(8'h20, d);
        check(d, 8'h00);
        $display("test registers done");
        for (i = 0; i < 8; i++) begin
            for (k = 0; k < 4; k++) begin
                wr({4'(4 + i % 4), 4'(4 + k)}, 8'(32'h12345678 >> (24 - 8 * k)));
                wr({4'(4 + i % 4), 4'(8 + k)}, 8'(32'hFF00F00F >> (24 - 8 * k)));
            end
            wr({4'(4 + i % 4), 4'h3}, modes[i]);
            exp_cnt = 0;
            for (m = 0; m < 2; m++) begin
                act = modes[i][3] && ((m == 1) == modes[i][0]);
                ob = out_cells;
                eb = ext_cells;
                u_src.send_cell(m ? 32'h12AB5F58 : 32'h12AB4F58, ucf_pkg::CELL_BYTES);
                drain();
                check(out_cells - ob, !(act && modes[i][1]));
                check(ext_cells - eb, act && modes[i][2]);
                exp_cnt += act && (modes[i][1] || modes[i][2]);
            end
            rd_count(i % 4, cnt);
            check(cnt, exp_cnt);
            rd_count(i % 4, cnt);
            check(cnt, 0);
            wr({4'(4 + i % 4), 4'h3}, 8'h08);
        end
        check(ext_bytes, ucf_pkg::CELL_BYTES * ext_cells);
        $display("test filter modes done");
        ob = out_bytes;
        out_ready = 1'b0;
        exp_b1 = 8'h00;
        fork
            u_src.send_cell(32'h00000000, ucf_pkg::CELL_BYTES);
        join_none
        w = 0;
        while (in_ready !== 1'b0 && w < 100) begin
            @(negedge clk);
            w++;
        end
        check(in_ready, 1'b0);
        out_ready = 1'b1;
        drain();
        check(out_bytes - ob, ucf_pkg::CELL_BYTES);
        $display("test buffer stall done");
        summarize();
    end
endmodule
